// >>> logic/alu_flag_unit.sv
// Combinational ALU that computes the result and its status flags
module alu_flag_unit
  import core_regs_pkg::*;
(
  alu_flags_if.alu f
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] b_eff;

  always_comb
  begin
    b_eff         = (f.op == op_sub) ? (~f.b + 8'h01) : f.b;     // see [RULE6]
    sum           = {1'b0, f.a} + {1'b0, b_eff};
    nib           = {1'b0, f.a[3:0]} + {1'b0, b_eff[3:0]};
    f.result      = 8'h00;
    f.carry       = 1'b0;
    f.nibble      = 1'b0;
    f.sets_carry  = 1'b0;
    f.sets_nibble = 1'b0;
    case (f.op)
      op_add, op_sub:
      begin
        f.result      = sum[7:0];
        // Subtract: two's complement add, so carry is inverted borrow
        f.carry       = sum[8] | ((f.op == op_sub) && (f.b == 8'h00));  // see [RULE5]
        f.nibble      = ((nib & nib_carry_bit) != 5'h00)
                        | ((f.op == op_sub) && (f.b[3:0] == 4'h0));    // see [RULE4]
        f.sets_carry  = 1'b1;
        f.sets_nibble = 1'b1;
      end
      op_and: f.result = f.a & f.b;
      op_or:  f.result = f.a | f.b;
      op_xor: f.result = f.a ^ f.b;
      op_rlf:
      begin
        f.result     = {f.a[6:0], f.carry_in};
        f.carry      = f.a[7];                                        // see [RULE6]
        f.sets_carry = 1'b1;
      end
      op_rrf:
      begin
        f.result     = {f.carry_in, f.a[7:1]};
        f.carry      = f.a[0];                                        // see [RULE6]
        f.sets_carry = 1'b1;
      end
      op_clr: f.result = 8'h00;
      default: f.result = 8'h00;
    endcase
    f.zero = (f.result == 8'h00) && (f.op != op_rlf) && (f.op != op_rrf);  // see [RULE17]
  end

endmodule // alu_flag_unit

// >>> logic/alu_status_and_option_regs.sv
// Status and option registers behind an AXI4-Lite slave
//
// Behaviour
// [RULE1] Indirect bank select is bit 7; software keeps it clear.
// [RULE2] Direct bank bits 00 pick bank 0, 01 bank 1; 128 bytes each.
// [RULE3] Software keeps the upper direct bank select bit cleared.
// [RULE4] Nibble flag is carry from bit 3; inverted borrow on subtract.
// [RULE5] Carry flag is carry out of bit 7; inverted borrow on subtract.
// [RULE6] Subtract adds two's complement; rotates load carry from end bit.
// [RULE7] Option register controls shared prescaler, irq edge, source, pull-ups.
// [RULE8] Timer 0 at 1:1 means prescaler assigned to the watchdog.
// [RULE9] Pull-up disable 1 turns off all port B pull-ups.
// [RULE10] Irq edge bit 1 rising, 0 falling.
// [RULE11] Source bit 1 external pin, 0 instruction clock.
// [RULE12] Source edge bit 1 falling, 0 rising.
// [RULE13] Ratio field 000 gives 1:2, doubling up to 1:256.
// [RULE14] Flag-setting op to status overrides written zero, nibble, carry.
// [RULE15] Expiry and sleep flags are read-only to writes.
// [RULE16] Expiry set by power-up, clear-wdt, sleep; cleared by time-out.
// [RULE17] Zero flag follows whether the result is zero. Rotates do not set it from a zero test here.
// [RULE18] Owner bit 1 gives prescaler to watchdog, 0 to timer 0.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module alu_status_and_option_regs
  import core_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pullups_off,
  output logic             irq_rising,
  output logic             t0_external,
  output logic             t0_falling,
  output logic             owner_watchdog,
  output logic [8:0]       t0_ratio,
  output logic [7:0]       data_bank_base
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0]  status_q;
  logic [7:0]  option_q;
  logic [7:0]  opnd_a_q;
  logic [7:0]  opnd_b_q;
  logic [7:0]  result_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        lane0;
  logic        alu_go;
  logic [2:0]  alu_op_w;
  logic        to_status;
  logic        evt_go;
  logic [1:0]  evt_w;
  logic        aw_held_d;
  logic        w_held_d;
  logic        bvalid_d;
  logic        rvalid_d;

  alu_flags_if f ();

  alu_flag_unit u_alu
  (
    .f (f)
  );

  option_decode u_dec
  (
    .clk            (clk),
    .reset_n        (reset_n),
    .option_q       (option_q),
    .pullups_off    (pullups_off),
    .irq_rising     (irq_rising),
    .t0_external    (t0_external),
    .t0_falling     (t0_falling),
    .owner_watchdog (owner_watchdog),
    .t0_ratio       (t0_ratio)
  );

  // ------------------------------------------------------------------
  // Write channel capture
  // ------------------------------------------------------------------
  assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;
  assign lane0         = wstrb_q[0];
  // Next-state view so the ready outputs come from flops
  assign aw_held_d     = (aw_held_q || (s_axi_awvalid && s_axi_awready)) && !do_write;
  assign w_held_d      = (w_held_q || (s_axi_wvalid && s_axi_wready)) && !do_write;
  assign bvalid_d      = do_write || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_d      = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
    end
    else
    begin
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready  <= !w_held_d && !bvalid_d;
      s_axi_arready <= !rvalid_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == status_addr) || (a == option_addr) || (a == alu_cmd_addr)
                 || (a == alu_opnd_addr) || (a == alu_result_addr)
                 || (a == reset_event_addr) || (a == derived_addr);
  endfunction

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= axi_okay;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_addr(awaddr_q) ? axi_okay : axi_slverr;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  assign alu_go    = do_write && lane0 && (awaddr_q == alu_cmd_addr);
  assign alu_op_w  = wdata_q[2:0];
  assign to_status = wdata_q[3];
  assign evt_go    = do_write && lane0 && (awaddr_q == reset_event_addr);
  assign evt_w     = wdata_q[1:0];

  assign f.op       = alu_op_w;
  assign f.a        = opnd_a_q;
  assign f.b        = opnd_b_q;
  assign f.carry_in = status_q[st_carry];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      opnd_a_q <= 8'h00;
      opnd_b_q <= 8'h00;
      result_q <= 8'h00;
    end
    else
    begin
      if (do_write && (awaddr_q == alu_opnd_addr))
      begin
        if (wstrb_q[0])
          opnd_a_q <= wdata_q[7:0];
        if (wstrb_q[1])
          opnd_b_q <= wdata_q[15:8];
      end
      if (alu_go)
        result_q <= f.result;
    end
  end

  // ------------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      status_q <= status_reset;                                  // see [RULE16]
    end
    else if (alu_go)
    begin
      // Result lands in status: only writable bits take it
      if (to_status)
        status_q <= (status_q & ~status_sw_mask) | (f.result & status_sw_mask);
      status_q[st_zero] <= f.zero | (alu_op_w == op_clr);       // see [RULE14] [RULE17]
      if (f.sets_carry)
        status_q[st_carry] <= f.carry;                           // see [RULE5] [RULE14]
      if (f.sets_nibble)
        status_q[st_nibble] <= f.nibble;                         // see [RULE4] [RULE14]
      if ((alu_op_w == op_rlf) || (alu_op_w == op_rrf))
        status_q[st_zero] <= to_status ? f.result[st_zero] : status_q[st_zero];
    end
    else if (evt_go)
    begin
      case (evt_w)
        ev_wdt_clr:
        begin
          status_q[st_expiry] <= 1'b1;                           // see [RULE16]
          status_q[st_sleep]  <= 1'b1;
        end
        ev_sleep:
        begin
          status_q[st_expiry] <= 1'b1;                           // see [RULE16]
          status_q[st_sleep]  <= 1'b0;
        end
        ev_timeout: status_q[st_expiry] <= 1'b0;                 // see [RULE16]
        default: status_q <= status_q;
      endcase
    end
    else if (do_write && lane0 && (awaddr_q == status_addr))
    begin
      // Expiry, sleep, upper bank and indirect bits hold; rest is writable
      status_q <= (status_q & ~status_sw_mask)
                  | (wdata_q[7:0] & status_sw_mask);             // see [RULE15] [RULE1] [RULE3]
    end
  end

  // ------------------------------------------------------------------
  // Option register and bank base
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      option_q <= option_reset;
    else if (do_write && lane0 && (awaddr_q == option_addr))
      option_q <= wdata_q[7:0];                                  // see [RULE7]
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      data_bank_base <= 8'h00;
    else
      data_bank_base <= status_q[st_bank_lo] ? bank_size : 8'h00;  // see [RULE2]
  end

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      status_addr:      read_mux = status_q;
      option_addr:      read_mux = option_q;
      alu_opnd_addr:    read_mux = opnd_a_q;
      alu_result_addr:  read_mux = result_q;
      derived_addr:     read_mux = t0_ratio[8:1];
      default:          read_mux = 8'h00;
    endcase
  endfunction


  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= axi_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, read_mux(s_axi_araddr)};
      s_axi_rresp  <= known_addr(s_axi_araddr) ? axi_okay : axi_slverr;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // alu_status_and_option_regs

// >>> logic/option_decode.sv
// Registered decode of the option settings into consumer controls
module option_decode
  import core_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] option_q,
  output logic            pullups_off,
  output logic            irq_rising,
  output logic            t0_external,
  output logic            t0_falling,
  output logic            owner_watchdog,
  output logic [8:0]      t0_ratio
);

  // Ratio while the watchdog owns the prescaler
  localparam logic [8:0] ratio_one = 9'h001;

  // Ratio 1:2 at code 0, doubling each step
  function automatic logic [8:0] ratio_of(input logic [2:0] code);
    ratio_of = ratio_base << code;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pullups_off    <= option_reset[op_pullup];
      irq_rising     <= option_reset[op_irq_edge];
      t0_external    <= option_reset[op_t0_src];
      t0_falling     <= option_reset[op_t0_edge];
      owner_watchdog <= option_reset[op_owner];
      t0_ratio       <= ratio_one;
    end
    else
    begin
      pullups_off    <= option_q[op_pullup];                  // see [RULE9]
      irq_rising     <= option_q[op_irq_edge];                // see [RULE10]
      t0_external    <= option_q[op_t0_src];                  // see [RULE11]
      t0_falling     <= option_q[op_t0_edge];                 // see [RULE12]
      owner_watchdog <= option_q[op_owner];                   // see [RULE18]
      // Watchdog ownership leaves timer 0 at 1:1
      t0_ratio <= option_q[op_owner] ? ratio_one
                  : ratio_of(option_q[op_ratio_lsb +: 3]);    // see [RULE13] [RULE8]
    end
  end

endmodule // option_decode

// >>> shared/alu_flags_if.sv
// Interface: ALU operation request and resulting flags
interface alu_flags_if;
  import core_regs_pkg::*;
  logic [2:0] op;
  logic [7:0] a;
  logic [7:0] b;
  logic       carry_in;
  logic [7:0] result;
  logic       carry;
  logic       nibble;
  logic       zero;
  logic       sets_carry;
  logic       sets_nibble;

  modport core (output op, output a, output b, output carry_in,
                input result, input carry, input nibble, input zero,
                input sets_carry, input sets_nibble);
  modport alu  (input op, input a, input b, input carry_in,
                output result, output carry, output nibble, output zero,
                output sets_carry, output sets_nibble);
endinterface

// >>> shared/core_regs_pkg.sv
// Package: register map, field positions, reset values and ALU operation and reset event types
package core_regs_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ------------------------------------------------------------------
  localparam logic [7:0] status_addr      = 8'h0c;
  localparam logic [7:0] option_addr      = 8'h04;
  localparam logic [7:0] alu_cmd_addr     = 8'h10;
  localparam logic [7:0] alu_opnd_addr    = 8'h14;
  localparam logic [7:0] alu_result_addr  = 8'h18;
  localparam logic [7:0] reset_event_addr = 8'h1c;
  localparam logic [7:0] derived_addr     = 8'h20;
  localparam int         status_index     = 8'h03;
  localparam int         option_index     = 8'h81;

  // ------------------------------------------------------------------
  // Status fields
  // ------------------------------------------------------------------
  localparam int st_carry    = 0;
  localparam int st_nibble   = 1;
  localparam int st_zero     = 2;
  localparam int st_sleep    = 3;
  localparam int st_expiry   = 4;
  localparam int st_bank_lo  = 5;
  localparam int st_bank_hi  = 6;
  localparam int st_indirect = 7;
  localparam logic [7:0] status_reset      = 8'h18;
  localparam logic [7:0] status_sw_mask    = 8'h27;

  // ------------------------------------------------------------------
  // Option fields
  // ------------------------------------------------------------------
  localparam int op_ratio_lsb = 0;
  localparam int op_owner     = 3;
  localparam int op_t0_edge   = 4;
  localparam int op_t0_src    = 5;
  localparam int op_irq_edge  = 6;
  localparam int op_pullup    = 7;
  localparam logic [7:0] option_reset = 8'hff;

  // ------------------------------------------------------------------
  // Misc constants
  // ------------------------------------------------------------------
  localparam logic [7:0] bank_size     = 8'h80;
  localparam logic [8:0] ratio_base    = 9'h002;
  localparam logic [1:0] axi_okay      = 2'b00;
  localparam logic [1:0] axi_slverr    = 2'b10;
  localparam logic [4:0] nib_carry_bit = 5'h10;

  // ------------------------------------------------------------------
  // ALU operations issued through the command register
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    op_add = 3'b000,
    op_sub = 3'b001,
    op_and = 3'b010,
    op_or  = 3'b011,
    op_xor = 3'b100,
    op_rlf = 3'b101,
    op_rrf = 3'b110,
    op_clr = 3'b111
  } alu_op_t;

  // Reset-cause events
  typedef enum logic [1:0]
  {
    ev_none    = 2'b00,
    ev_wdt_clr = 2'b01,
    ev_sleep   = 2'b10,
    ev_timeout = 2'b11
  } reset_event_t;

endpackage

// >>> test/regs_sva.sv
// Checker: bus answer and decoded option output properties
module regs_sva
  import core_regs_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pullups_off,
  input wire logic        irq_rising,
  input wire logic        t0_external,
  input wire logic        t0_falling,
  input wire logic        owner_watchdog,
  input wire logic [8:0]  t0_ratio,
  input wire logic [7:0]  data_bank_base
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  a_no_new_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20
    |=> s_axi_rresp == axi_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_owner_ratio: assert property (owner_watchdog |-> t0_ratio == 9'h001)
    else $error("ratio not 1 with watchdog owner");
  a_ratio_power: assert property (
    !owner_watchdog |-> $onehot(t0_ratio) && !t0_ratio[0])
    else $error("ratio not a power of two from 2");
  a_bank_base: assert property (
    data_bank_base == 8'h00 || data_bank_base == bank_size)
    else $error("bank base out of range");
  a_reset_defaults: assert property (
    $rose(reset_n) |-> pullups_off && irq_rising && t0_external && t0_falling
    && owner_watchdog && data_bank_base == 8'h00)
    else $error("decoded outputs wrong after reset");
endmodule // regs_sva

bind alu_status_and_option_regs regs_sva u_sva (.clk, .reset_n, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pullups_off, .irq_rising, .t0_external, .t0_falling,
  .owner_watchdog, .t0_ratio, .data_bank_base);

// >>> test/tb.sv
// Testbench: register access, option decode and flag model checks
module tb
  import core_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, reset_n, aw_valid, w_valid, b_ready, ar_valid, r_ready;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic        pullups_off, irq_rising, t0_external, t0_falling, owner_watchdog;
  logic [7:0]  aw_addr, ar_addr, data_bank_base, st_e, res_e;
  logic [31:0] w_data, r_data;
  logic [3:0]  w_strb;
  logic [1:0]  b_resp, r_resp;
  logic [8:0]  t0_ratio;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  alu_status_and_option_regs uut (.clk, .reset_n, .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
    .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
    .s_axi_rready(r_ready), .pullups_off, .irq_rising, .t0_external, .t0_falling,
    .owner_watchdog, .t0_ratio, .data_bank_base);

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] er = axi_okay);
    int lag;
    lag = $urandom % 4;
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    w_strb <= s;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= (lag == 0);
    forever
    begin
      @(posedge clk);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid && b_ready) break;
      lag--;
      if (lag <= 0) b_ready <= 1'b1;
    end
    b_ready <= 1'b0;
    check("bresp", 32'(er), 32'(b_resp));
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = axi_okay);
    int lag;
    lag = $urandom % 4;
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= (lag == 0);
    forever
    begin
      @(posedge clk);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid && r_ready) break;
      lag--;
      if (lag <= 0) r_ready <= 1'b1;
    end
    r_ready <= 1'b0;
    check(nm, e, r_data);
    check("rresp", 32'(er), 32'(r_resp));
  endtask

  function automatic logic [8:0] ratio(input logic [7:0] v);
    return v[3] ? 9'h001 : ratio_base << v[2:0];
  endfunction

  task automatic opt_chk(input logic [7:0] v);
    rd("option", option_addr, {24'h0, v});
    #1;
    check("decoded", 32'({v[7:3], ratio(v)}),
          32'({pullups_off, irq_rising, t0_external, t0_falling, owner_watchdog,
          t0_ratio}));
    rd("derived", derived_addr, {23'h0, ratio(v)} >> 1);
  endtask

  task automatic st_chk;
    rd("status", status_addr, {24'h0, st_e});
    #1;
    check("bank", 32'(st_e[5] ? bank_size : 8'h00), 32'(data_bank_base));
  endtask

  task automatic alu_run(input logic [2:0] op, input logic [7:0] a, b, input logic t);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + (op[0] ? {1'b0, ~b} + 9'h1 : {1'b0, b});
    n = {1'b0, a[3:0]} + (op[0] ? {1'b0, ~b[3:0]} + 5'h1 : {1'b0, b[3:0]});
    case (op)
      3'd0, 3'd1: res_e = s[7:0];
      3'd2: res_e = a & b;
      3'd3: res_e = a | b;
      3'd4: res_e = a ^ b;
      3'd5: res_e = {a[6:0], st_e[0]};
      3'd6: res_e = {st_e[0], a[7:1]};
      default: res_e = 8'h00;
    endcase
    if (t) st_e = (st_e & ~status_sw_mask) | (res_e & status_sw_mask);
    if (op < 3'd2) st_e[1:0] = {n[4], s[8]};
    if (op == 3'd5 || op == 3'd6) st_e[0] = op[0] ? a[7] : a[0];
    if (op < 3'd5 || op == 3'd7) st_e[2] = (res_e == 8'h00);
    wr(alu_opnd_addr, {16'h0, b, a});
    wr(alu_cmd_addr, {28'h0, t, op});
    rd("result", alu_result_addr, {24'h0, res_e});
    st_chk();
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] v;
    static logic [1:0] evs [4] = '{2'd3, 2'd2, 2'd3, 2'd1};
    clk = 1'b0;
    reset_n = 1'b0;
    {aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
    {aw_addr, ar_addr, w_data, w_strb} = '0;
    st_e = status_reset;
    void'($urandom(8532));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    st_chk();
    opt_chk(option_reset);
    for (int i = 0; i < 16; i++)
    begin
      v = 8'($urandom);
      if (i < 8) v[3:0] = {1'b0, 3'(i)};
      wr(option_addr, {24'h0, v});
      opt_chk(v);
    end
    wr(option_addr, 32'h0, 4'h0);
    opt_chk(v);
    wr(status_addr, 32'hff);
    st_e = st_e | status_sw_mask;
    st_chk();
    wr(status_addr, 32'h0);
    st_e = st_e & ~status_sw_mask;
    st_chk();
    foreach (evs[i])
    begin
      wr(reset_event_addr, {30'h0, evs[i]});
      if (evs[i] == 2'd3) st_e[4] = 1'b0;
      else st_e[4:3] = {1'b1, evs[i][0]};
      st_chk();
    end
    alu_run(op_add, 8'hff, 8'h01, 1'b0);
    alu_run(op_sub, 8'h10, 8'h01, 1'b0);
    alu_run(op_sub, 8'h05, 8'h05, 1'b0);
    alu_run(op_sub, 8'h01, 8'h02, 1'b0);
    alu_run(op_and, 8'hf0, 8'h0f, 1'b0);
    alu_run(op_or, 8'h00, 8'h00, 1'b0);
    alu_run(op_xor, 8'h5a, 8'h0f, 1'b0);
    alu_run(op_rlf, 8'h80, 8'h00, 1'b0);
    alu_run(op_rrf, 8'h01, 8'h00, 1'b0);
    alu_run(op_clr, 8'h33, 8'h00, 1'b0);
    alu_run(op_add, 8'h1f, 8'h01, 1'b1);
    alu_run(op_sub, 8'h05, 8'h05, 1'b1);
    for (int i = 0; i < 20; i++)
      alu_run(3'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
    rd("unmapped", 8'h40, 32'h0, axi_slverr);
    wr(8'h40, 32'h0, 4'hf, axi_slverr);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    st_e = status_reset;
    st_chk();
    opt_chk(option_reset);
    report_and_stop();
  end
endmodule // tb
